// File: servo_cmd_pkg.sv
package servo_cmd_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_MODE    = 8'h00;
  localparam logic [7:0] OFS_FN_LO   = 8'h04;
  localparam logic [7:0] OFS_FN_HI   = 8'h08;
  localparam logic [7:0] OFS_SPEED_SELECT_BIT1    = 8'h0C;
  localparam logic [7:0] OFS_SPD2    = 8'h10;
  localparam logic [7:0] OFS_SPD3    = 8'h14;
  localparam logic [7:0] OFS_STATUS  = 8'h18;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h20;
  localparam logic [7:0] OFS_RESTART = 8'h24;
  localparam logic [1:0] POS_WIN     = 2'h1;
  // input function codes
  localparam logic [7:0] FN_NONE   = 8'h00;
  localparam logic [7:0] FN_ENABLE = 8'h65;
  localparam logic [7:0] FN_ALARM_RESET_IN   = 8'h66;
  localparam logic [7:0] FN_TRIG   = 8'h6C;
  localparam logic [7:0] FN_TORQUE = 8'h6D;
  localparam logic [7:0] FN_POSITION_SELECT_BIT0   = 8'h6F;
  localparam logic [7:0] FN_POSITION_SELECT_BIT1   = 8'h70;
  localparam logic [7:0] FN_POSITION_SELECT_BIT2   = 8'h71;
  localparam logic [7:0] FN_SPEED_SELECT_BIT0   = 8'h72;
  localparam logic [7:0] FN_SPEED_SELECT_BIT1   = 8'h73;
  localparam logic [7:0] FN_OPST   = 8'h15;
  localparam logic [7:0] FN_REV    = 8'h16;
  localparam logic [7:0] FN_FWD    = 8'h17;
  // reset values
  localparam logic [31:0] FN_LO_RST = 32'h7372_6D65;
  localparam logic [31:0] FN_HI_RST = 32'h1517_1666;
  localparam logic [1:0]  MODE_RST  = 2'h2;
  localparam logic [16:0] SPD_MAX   = 17'h0_EA60;
  // status and irq field positions
  localparam int unsigned ST_EN    = 2;
  localparam int unsigned ST_ALM   = 3;
  localparam int unsigned ST_IDX   = 6;
  localparam int unsigned IRQ_TRIG = 3;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_POS = 2'b01,
    MODE_SPD = 2'b10
  } mode_e;

  typedef struct packed {
    logic [31:0] attr;
    logic [31:0] target;
  } pos_cmd_s;

  typedef struct packed {
    logic stop;
    logic fwd;
    logic rev;
  } alarm_s;
endpackage : servo_cmd_pkg

// File: servo_input_command_select.sv
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
// Contract
// R1: setting 02 selects speed mode
// R2: setting 01 selects position mode
// R3: new mode applies only after restart
// R4: enable input function 101 powers stage
// R5: dropping enable stops drive
// R6: function code 0 does nothing
// R7: inputs 6,7,8 default reverse, forward, stop
// R8: default limit/stop assignments raise alarms
// R9: restart or alarm reset 102 clears
// R10: speed select codes 114 and 115
// R11: both off selects analog reference
// R12: codes 01,10,11 pick stored speeds
// R13: stored speeds clamp to plus-minus 60000
// R14: stored speed unit is 0.1 rpm
// R15: three select bits pick eight targets
// R16: controller assigns 113 for third bit
// R17: stored targets are absolute positions
// R18: trigger rising edge latches selected target
module servo_input_command_select
  import servo_cmd_pkg::*;
(
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               reset,
  // axi4-lite write
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // digital inputs, bit 0 is input_one
  input  wire logic [7:0]         din,
  // drive outputs
  output logic                    power_stage_en,
  output logic                    torque_limit_en,
  output logic                    analog_speed_choice,
  output logic signed [16:0]      speed_cmd,
  output pos_cmd_s                pos_cmd,
  output logic                    pos_start,
  output alarm_s                  alarm,
  output logic                    irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset); // async reset also voids the checks

  // true when any input carrying this function is on
  function automatic logic fn_hit(logic [63:0] f, logic [7:0] d,
                                  logic [7:0] c);
    fn_hit = 1'b0;
    for (int i = 0; i < 8; i++)
      if (c != FN_NONE && f[i*8 +: 8] == c && d[i]) // [R6]
        fn_hit = 1'b1;
  endfunction : fn_hit

  // true when some input carries this function
  function automatic logic fn_used(logic [63:0] f, logic [7:0] c);
    fn_used = 1'b0;
    for (int i = 0; i < 8; i++)
      if (f[i*8 +: 8] == c)
        fn_used = 1'b1;
  endfunction : fn_used

  // byte-lane merge for partial writes
  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n,
                                        logic [3:0] s);
    for (int b = 0; b < 4; b++)
      merge[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
  endfunction : merge

  // saturate a written speed into the legal window
  function automatic logic [16:0] clamp(logic [31:0] v);
    if ($signed(v) > $signed({15'h0, SPD_MAX}))
      clamp = SPD_MAX; // [R13]
    else if ($signed(v) < -$signed({15'h0, SPD_MAX}))
      clamp = 17'(-$signed({15'h0, SPD_MAX})); // [R13]
    else
      clamp = v[16:0];
  endfunction : clamp

  logic [1:0]         mode_set_q;
  mode_e              mode_q;
  logic               boot_q;
  logic [63:0]        fn_q;
  logic [2:0][16:0]   spd_q;
  logic [31:0]        pos_mem [16];
  logic [3:0]         irq_st_q;
  logic [3:0]         irq_msk_q;
  logic               trig_q;
  logic               alarm_reset_in_q;
  logic [2:0]         pos_idx_q;
  logic               wr_en;
  logic               rd_en;
  logic               load;
  logic               restart;
  logic               en_in;
  logic               trig_rise;
  logic               alm_clr;
  logic [2:0]         alm_cond;
  logic [1:0]         spd_sel;
  logic [2:0]         pos_sel;
  logic [31:0]        rd_word;
  logic               rd_ok;

  assign wr_en     = s_axi_awready;
  assign rd_en     = s_axi_arready;
  assign restart   = wr_en && s_axi_awaddr == OFS_RESTART
                     && s_axi_wstrb[0] && s_axi_wdata[0];
  assign load      = !boot_q || restart; // boot edge acts as power-up
  assign en_in     = fn_hit(fn_q, din, FN_ENABLE);
  assign trig_rise = fn_hit(fn_q, din, FN_TRIG) && !trig_q;
  assign alm_clr   = (fn_hit(fn_q, din, FN_ALARM_RESET_IN) && !alarm_reset_in_q)
                     || restart; // [R9]
  assign spd_sel   = {fn_hit(fn_q, din, FN_SPEED_SELECT_BIT1),
                      fn_hit(fn_q, din, FN_SPEED_SELECT_BIT0)}; // [R10]
  // third bit only works once some input is given 113
  assign pos_sel   = {fn_hit(fn_q, din, FN_POSITION_SELECT_BIT2), // [R16]
                      fn_hit(fn_q, din, FN_POSITION_SELECT_BIT1),
                      fn_hit(fn_q, din, FN_POSITION_SELECT_BIT0)}; // [R15]
  // an assigned limit or stop input that is off trips
  assign alm_cond  = {fn_used(fn_q, FN_OPST) && !fn_hit(fn_q, din, FN_OPST),
                      fn_used(fn_q, FN_FWD) && !fn_hit(fn_q, din, FN_FWD),
                      fn_used(fn_q, FN_REV) && !fn_hit(fn_q, din, FN_REV)};

  // write address and data taken together, one at a time
  always_ff @(posedge core_clk or posedge reset)
    if (reset)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
    end
    else
    begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
                       && !s_axi_awready;
      s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
                       && !s_axi_awready;
      if (wr_en)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (s_axi_awaddr[7:6] == POS_WIN
                        || s_axi_awaddr <= OFS_RESTART)
                        && s_axi_awaddr[1:0] == 2'h0 ? RESP_OK : RESP_ERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end

  // read decode
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_ok   = s_axi_araddr[1:0] == 2'h0;
    if (s_axi_araddr[7:6] == POS_WIN)
      rd_word = pos_mem[s_axi_araddr[5:2]];
    else
      unique case (s_axi_araddr)
        OFS_MODE:    rd_word = {30'h0, mode_set_q};
        OFS_FN_LO:   rd_word = fn_q[31:0];
        OFS_FN_HI:   rd_word = fn_q[63:32];
        OFS_SPEED_SELECT_BIT1:    rd_word = 32'(signed'(spd_q[0]));
        OFS_SPD2:    rd_word = 32'(signed'(spd_q[1]));
        OFS_SPD3:    rd_word = 32'(signed'(spd_q[2]));
        OFS_STATUS:  rd_word = {23'h0, pos_idx_q, alarm,
                                power_stage_en, mode_q};
        OFS_IRQ_ST:  rd_word = {28'h0, irq_st_q};
        OFS_IRQ_MSK: rd_word = {28'h0, irq_msk_q};
        OFS_RESTART: rd_word = 32'h0000_0000;
        default:     rd_ok = 1'b0;
      endcase
  end

  // read channel, answer one cycle after the address is taken
  always_ff @(posedge core_clk or posedge reset)
    if (reset)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OK;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_en)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_ok ? rd_word : 32'h0000_0000;
        s_axi_rresp  <= rd_ok ? RESP_OK : RESP_ERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end

  // configuration registers
  always_ff @(posedge core_clk or posedge reset)
    if (reset)
    begin
      mode_set_q <= MODE_RST;
      fn_q       <= {FN_HI_RST, FN_LO_RST}; // [R7]
      spd_q      <= '0;
      irq_msk_q  <= 4'h0;
    end
    else if (wr_en)
      unique case (s_axi_awaddr)
        OFS_MODE:    mode_set_q <= 2'(merge({30'h0, mode_set_q},
                                         s_axi_wdata, s_axi_wstrb));
        OFS_FN_LO:   fn_q[31:0] <= merge(fn_q[31:0], s_axi_wdata,
                                         s_axi_wstrb);
        OFS_FN_HI:   fn_q[63:32] <= merge(fn_q[63:32], s_axi_wdata,
                                          s_axi_wstrb);
        OFS_SPEED_SELECT_BIT1:    spd_q[0] <= clamp(merge(32'(signed'(spd_q[0])),
                                       s_axi_wdata, s_axi_wstrb));
        OFS_SPD2:    spd_q[1] <= clamp(merge(32'(signed'(spd_q[1])),
                                       s_axi_wdata, s_axi_wstrb));
        OFS_SPD3:    spd_q[2] <= clamp(merge(32'(signed'(spd_q[2])),
                                       s_axi_wdata, s_axi_wstrb));
        OFS_IRQ_MSK: irq_msk_q <= 4'(merge({28'h0, irq_msk_q},
                                        s_axi_wdata, s_axi_wstrb));
        default:     ;
      endcase

  // position table holds no reset, software fills it before use
  always_ff @(posedge core_clk)
    if (wr_en && s_axi_awaddr[7:6] == POS_WIN && s_axi_awaddr[1:0] == 2'h0)
      pos_mem[s_axi_awaddr[5:2]] <= merge(pos_mem[s_axi_awaddr[5:2]],
                                          s_axi_wdata, s_axi_wstrb); // [R17]

  // active mode follows the setting only on restart
  always_ff @(posedge core_clk or posedge reset)
    if (reset)
    begin
      boot_q <= 1'b0;
      mode_q <= MODE_SPD;
    end
    else
    begin
      boot_q <= 1'b1;
      if (load && (mode_set_q == MODE_SPD || mode_set_q == MODE_POS))
        mode_q <= mode_e'(mode_set_q); // [R1] [R2] [R3]
    end

  // alarms are sticky; a fresh trip beats the clear
  always_ff @(posedge core_clk or posedge reset)
    if (reset)
    begin
      alarm  <= '0;
      alarm_reset_in_q <= 1'b0;
    end
    else
    begin
      alarm_reset_in_q <= fn_hit(fn_q, din, FN_ALARM_RESET_IN);
      alarm  <= (alarm & ~{3{alm_clr}}) | alm_cond; // [R8] [R9]
    end

  // power stage and speed reference
  always_ff @(posedge core_clk or posedge reset)
    if (reset)
    begin
      power_stage_en      <= 1'b0;
      torque_limit_en     <= 1'b0;
      analog_speed_choice <= 1'b0;
      speed_cmd           <= '0;
    end
    else
    begin
      // any alarm also holds the stage off
      power_stage_en  <= en_in && alm_cond == 3'h0
                         && alarm == 3'h0; // [R4] [R5]
      torque_limit_en <= fn_hit(fn_q, din, FN_TORQUE);
      analog_speed_choice <= mode_q == MODE_SPD
                             && spd_sel == 2'b00; // [R11]
      if (mode_q == MODE_SPD && spd_sel != 2'b00)
        speed_cmd <= spd_q[spd_sel - 2'd1]; // [R12] [R14]
      else
        speed_cmd <= '0;
    end

  // position command latch on trigger edge
  always_ff @(posedge core_clk or posedge reset)
    if (reset)
    begin
      trig_q    <= 1'b0;
      pos_start <= 1'b0;
      pos_idx_q <= 3'h0;
      pos_cmd   <= '0;
    end
    else
    begin
      trig_q    <= fn_hit(fn_q, din, FN_TRIG);
      pos_start <= 1'b0;
      if (trig_rise && mode_q == MODE_POS && en_in)
      begin
        pos_start <= 1'b1; // [R18]
        pos_idx_q <= pos_sel; // [R15]
        pos_cmd   <= {pos_mem[{pos_sel, 1'b0}],
                      pos_mem[{pos_sel, 1'b1}]}; // [R17]
      end
    end

  // interrupt status clears on read; a new event wins
  always_ff @(posedge core_clk or posedge reset)
    if (reset)
    begin
      irq_st_q <= 4'h0;
      irq      <= 1'b0;
    end
    else
    begin
      irq_st_q <= (irq_st_q & ~{4{rd_en && s_axi_araddr == OFS_IRQ_ST}})
                  | {trig_rise && mode_q == MODE_POS && en_in,
                     alm_cond & ~alarm};
      irq      <= |(irq_st_q & irq_msk_q);
    end

  a_mode_spd: assert property (load && mode_set_q == MODE_SPD // [R1]
    |=> mode_q == MODE_SPD)
    else $error("speed mode not taken");
  a_mode_pos: assert property (load && mode_set_q == MODE_POS // [R2]
    |=> mode_q == MODE_POS)
    else $error("position mode not taken");
  a_mode_hold: assert property (!load |=> $stable(mode_q)) // [R3]
    else $error("mode changed without restart");
  a_stage_on: assert property (en_in && alm_cond == 3'h0 // [R4]
    && alarm == 3'h0 |=> power_stage_en)
    else $error("stage not enabled");
  a_stage_off: assert property (!en_in |=> !power_stage_en) // [R5]
    else $error("stage still enabled");
  a_alarm_set: assert property (alm_cond[0] |=> alarm.rev // [R8]
    ##0 (irq_st_q[0] || $past(alarm.rev)))
    else $error("reverse alarm missed");
  a_alarm_clr: assert property (alm_clr && alm_cond == 3'h0 // [R9]
    |=> alarm == 3'h0)
    else $error("alarm not cleared");
  a_analog_sel: assert property (mode_q == MODE_SPD // [R11]
    && spd_sel == 2'b00 |=> analog_speed_choice && speed_cmd == '0)
    else $error("analog reference not chosen");
  a_speed_pick: assert property (mode_q == MODE_SPD // [R12]
    && spd_sel == 2'b11 && $stable(spd_q[2])
    |=> speed_cmd == $past(spd_q[2]))
    else $error("third stored speed not used");
  a_speed_range: assert property ($signed(speed_cmd) // [R13]
    <= $signed(SPD_MAX) && $signed(speed_cmd) >= -$signed(SPD_MAX))
    else $error("speed outside window");
  a_pos_latch: assert property (trig_rise && mode_q == MODE_POS // [R18]
    && en_in |=> pos_start && pos_idx_q == $past(pos_sel) ##1 !pos_start)
    else $error("trigger not latched once");
  c_speed_two: cover property (mode_q == MODE_SPD && spd_sel == 2'b10
    ##1 power_stage_en);
  c_pos_run: cover property (pos_start && pos_idx_q == 3'h7);
  c_alarm_rst: cover property (alarm != 3'h0 ##1 alarm == 3'h0);
endmodule : servo_input_command_select

// File: servo_ctrl_model.sv
`timescale 1ns/1ps
// machine controller at the far side, driving the drive's digital inputs
module servo_ctrl_model
(
  // clock
  input  wire logic       core_clk,
  // digital inputs toward the drive, bit 0 is input_one
  output logic [7:0]      din
);
  // every input is driven at all times, so no line is left floating
  initial din = 8'h00;

  // whole input word, launched just after an edge
  task automatic put(input logic [7:0] v);
    @(posedge core_clk);
    din <= v;
  endtask : put

  // select bits settle three cycles ahead of the trigger edge
  // layout: [4:2] select, [1] trigger, [0] enable
  task automatic fire(input logic [2:0] idx, input logic en);
    put({3'b000, idx, 1'b0, en});
    repeat (2) @(posedge core_clk);
    put({3'b000, idx, 1'b1, en});
    put({3'b000, idx, 1'b0, en});
  endtask : fire
endmodule : servo_ctrl_model

// File: servo_input_command_select_tb_top.sv
`timescale 1ns/1ps
module servo_input_command_select_tb_top
  import servo_cmd_pkg::*;
;
  localparam int LIM = 64;
  // clock, reset and bus master state
  logic              core_clk      = 1'b0;
  logic              reset         = 1'b1;
  logic [7:0]        s_axi_awaddr  = 8'h00;
  logic              s_axi_awvalid = 1'b0;
  logic [31:0]       s_axi_wdata   = 32'h0000_0000;
  logic [3:0]        s_axi_wstrb   = 4'hF;
  logic              s_axi_wvalid  = 1'b0;
  logic              s_axi_bready  = 1'b0;
  logic [7:0]        s_axi_araddr  = 8'h00;
  logic              s_axi_arvalid = 1'b0;
  logic              s_axi_rready  = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic              s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [31:0]       s_axi_rdata;
  logic [7:0]        din;
  logic              power_stage_en, torque_limit_en, analog_speed_choice;
  logic signed [16:0] speed_cmd;
  pos_cmd_s          pos_cmd;
  logic              pos_start, irq;
  alarm_s            alarm;
  // expectations, oldest first
  logic [63:0]       bq[$], rq[$], pq[$];
  logic [63:0]       pat [8];
  logic signed [16:0] spd [3];
  int                err_total = 0;
  int                checks    = 0;

  always #2.5 core_clk = ~core_clk;

  servo_input_command_select dut_u (
    .core_clk(core_clk), .reset(reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .din(din),
    .power_stage_en(power_stage_en), .torque_limit_en(torque_limit_en),
    .analog_speed_choice(analog_speed_choice), .speed_cmd(speed_cmd),
    .pos_cmd(pos_cmd), .pos_start(pos_start), .alarm(alarm), .irq(irq)
  );

  servo_ctrl_model ctrl_u (
    .core_clk(core_clk),
    .din(din)
  );

  task automatic end_of_test();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  task automatic cmp_val(input string what, input logic [63:0] exp,
                         input logic [63:0] got);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_val

  // an empty queue yields all ones, a value no bus response can carry
  function automatic logic [63:0] pop(ref logic [63:0] q[$]);
    if (q.size() == 0)
      return {64{1'b1}};
    return q.pop_front();
  endfunction : pop

  task automatic tick(ref int n);
    @(posedge core_clk);
    n++;
    if (n >= LIM)
    begin
      err_total++;
      $display("BAD wait_bound expected %0d seen %0d", LIM - 1, n);
      end_of_test();
    end
  endtask : tick

  task automatic settle();
    repeat (3) @(posedge core_clk);
  endtask : settle

  // write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] rsp = RESP_OK);
    int   n;
    logic aw_ok, w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    bq.push_back(64'(rsp));
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      tick(n);
      aw_ok = aw_ok | (s_axi_awready === 1'b1);
      w_ok = w_ok | (s_axi_wready === 1'b1);
      if (aw_ok)
        s_axi_awvalid <= 1'b0;
      if (w_ok)
        s_axi_wvalid <= 1'b0;
    end
    while (!(aw_ok && w_ok));
    while (s_axi_bvalid !== 1'b1)
      tick(n);
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] rsp = RESP_OK);
    int n;
    n = 0;
    rq.push_back(64'({rsp, d}));
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
      tick(n);
    while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1)
      tick(n);
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // result watcher: each answer retires the oldest note
  always @(posedge core_clk)
  begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      cmp_val("bresp", pop(bq), 64'(s_axi_bresp));
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      cmp_val("read", pop(rq), 64'({s_axi_rresp, s_axi_rdata}));
    if (pos_start === 1'b1)
      cmp_val("pos_cmd", pop(pq), pos_cmd);
  end

  // main sequence
  initial
  begin
    void'($urandom(32'h3b2e_3c85));
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    settle();
    axi_rd(OFS_MODE, 32'h0000_0002);
    axi_rd(OFS_FN_LO, FN_LO_RST);
    axi_rd(OFS_FN_HI, FN_HI_RST);
    axi_rd(8'h30, 32'h0000_0000, RESP_ERR);
    axi_wr(8'h3C, 32'h0000_0001, RESP_ERR);
    // all inputs off: limit and stop inputs trip, enable must be refused
    cmp_val("alarm", 64'h7, 64'(alarm));
    ctrl_u.put(8'h01);
    axi_wr(OFS_IRQ_MSK, 32'h0000_0007);
    settle();
    cmp_val("en_blocked", 64'h0, 64'(power_stage_en));
    cmp_val("irq", 64'h1, 64'(irq));
    ctrl_u.put(8'hE3);
    ctrl_u.put(8'hF3);
    ctrl_u.put(8'hE3);
    settle();
    cmp_val("alarm", 64'h0, 64'(alarm));
    cmp_val("enable", 64'h1, 64'(power_stage_en));
    cmp_val("torque", 64'h1, 64'(torque_limit_en));
    axi_rd(OFS_IRQ_ST, 32'h0000_0007);
    axi_rd(OFS_IRQ_ST, 32'h0000_0000);
    settle();
    cmp_val("irq", 64'h0, 64'(irq));
    // stored speeds, one beyond the limit, one random
    spd[0] = 17'sd60000;
    spd[1] = 17'($urandom_range(60000));
    spd[2] = -17'sd30000;
    axi_wr(OFS_SPEED_SELECT_BIT1, 32'd70000);
    axi_wr(OFS_SPD2, 32'(spd[1]));
    axi_wr(OFS_SPD3, 32'(spd[2]));
    axi_rd(OFS_SPEED_SELECT_BIT1, 32'd60000);
    axi_rd(OFS_SPD3, 32'hFFFF_8AD0);
    for (int s = 0; s < 4; s++)
    begin
      ctrl_u.put(8'hE1 | 8'(s << 2));
      settle();
      cmp_val("analog", 64'(s == 0), 64'(analog_speed_choice));
      cmp_val("speed", (s == 0) ? 64'h0 : 64'(spd[s - 1]),
              64'(speed_cmd));
    end
    // input three unassigned, then enable dropped
    axi_wr(OFS_FN_LO, 32'h7300_6D65);
    ctrl_u.put(8'hE4);
    settle();
    cmp_val("analog", 64'h1, 64'(analog_speed_choice));
    cmp_val("en_off", 64'h0, 64'(power_stage_en));
    // position mode only after restart
    axi_wr(OFS_MODE, 32'h0000_0001);
    axi_rd(OFS_STATUS, 32'h0000_0002);
    axi_wr(OFS_FN_LO, 32'h706F_6C65);
    axi_wr(OFS_FN_HI, 32'h0000_0071);
    axi_wr(OFS_RESTART, 32'h0000_0001);
    axi_rd(OFS_STATUS, 32'h0000_0001);
    cmp_val("speed_pos", 64'h0, 64'(speed_cmd));
    for (int k = 0; k < 8; k++)
    begin
      pat[k] = {$urandom(), $urandom()};
      axi_wr(8'h40 + 8'(8 * k), pat[k][63:32]);
      axi_wr(8'h44 + 8'(8 * k), pat[k][31:0]);
    end
    axi_wr(OFS_IRQ_MSK, 32'h0000_0008);
    for (int k = 0; k < 8; k++)
    begin
      pq.push_back(pat[k]);
      ctrl_u.fire(3'(k), 1'b1);
    end
    settle();
    cmp_val("pos_left", 64'h0, 64'(pq.size()));
    cmp_val("irq_trig", 64'h1, 64'(irq));
    axi_rd(OFS_STATUS, 32'h0000_01C5);
    axi_rd(OFS_IRQ_ST, 32'h0000_0008);
    // trigger without enable is refused; a stray start is caught above
    ctrl_u.fire(3'd2, 1'b0);
    settle();
    cmp_val("en_off", 64'h0, 64'(power_stage_en));
    end_of_test();
  end
endmodule : servo_input_command_select_tb_top
